/* File: verilog/tcs_regs_defs.vh */
// Constants for the tuner control and status register bank.
// Assumes inclusion by the bank module only; definitions only.
`ifndef TCS_REGS_DEFS_VH
`define TCS_REGS_DEFS_VH
// Register indices.
`define TCS_REG_DEVICE_ID 4'h0
`define TCS_REG_CHIP_ID 4'h1
`define TCS_REG_POWER 4'h2
`define TCS_REG_CHANNEL 4'h3
`define TCS_REG_SYSCFG1 4'h4
`define TCS_REG_SYSCFG2 4'h5
`define TCS_REG_STATUS 4'ha
`define TCS_REG_READBACK 4'hb
`define TCS_REG_RDS_A 4'hc
`define TCS_REG_RDS_B 4'hd
`define TCS_REG_RDS_C 4'he
`define TCS_REG_RDS_D 4'hf
`define TCS_WR_START 4'h2
`define TCS_RD_START 4'ha
// Power configuration fields.
`define TCS_PWR_MUTE_REL 14
`define TCS_PWR_SCAN_UP 9
`define TCS_PWR_SCAN 8
`define TCS_PWR_OFF 6
`define TCS_PWR_ON 0
`define TCS_PWR_MASK 16'h4341
// Channel fields.
`define TCS_CH_TUNE 15
`define TCS_CH_MASK 16'h83ff
// System configuration one fields.
`define TCS_C1_RDS_IEN 15
`define TCS_C1_TUNE_IEN 14
`define TCS_C1_RDS_EN 12
`define TCS_C1_EMPH 11
`define TCS_C1_GP2_HI 3
`define TCS_C1_GP2_LO 2
`define TCS_C1_MASK 16'hd80c
// System configuration two fields.
`define TCS_C2_TH_HI 15
`define TCS_C2_TH_LO 8
`define TCS_C2_REGION 6
`define TCS_C2_SP_HI 5
`define TCS_C2_SP_LO 4
`define TCS_C2_VOL_HI 3
`define TCS_C2_MASK 16'hff7f
// General pin function codes.
`define TCS_GP_HIZ 2'h0
`define TCS_GP_IRQ 2'h1
`define TCS_GP_LOW 2'h2
// Spacing codes, base and spacing figures in kHz, and top station indices of each band.
`define TCS_SP_200 2'h0
`define TCS_SP_100 2'h1
`define TCS_BASE0_KHZ 18'h155cc
`define TCS_BASE1_KHZ 18'h128e0
`define TCS_KHZ_200 18'h000c8
`define TCS_KHZ_100 18'h00064
`define TCS_KHZ_50 18'h00032
`define TCS_TOP0_200 10'h066
`define TCS_TOP0_100 10'h0cd
`define TCS_TOP0_50 10'h19a
`define TCS_TOP1_200 10'h046
`define TCS_TOP1_100 10'h08c
`define TCS_TOP1_50 10'h118
`endif

/* File: verilog/tcs_regs.v */
// Tuner control and status register bank: registers, power control, tune and seek sequencing.
// Assumes a serial front end that hands over bytes on mclk, and an analog section that reports
// signal level, stereo and decoded data groups synchronously to mclk.
//
// Operation
// R1: Power-on high, power-off low enters operation; mute-release high unmutes audio.
// R2: Power-on and power-off both high runs power-down sequence, then clears power-on.
// R3: Host clearing power-on directly gives only partial power-down.
// R4: Tune-done enable and pin function 01 pull general pin low on completion.
// R5: Data-ready enable and pin function 01 pull general pin low on new group.
// R6: Emphasis select chooses de-emphasis time constant; zero means 75 us.
// R7: Second configuration holds threshold, volume, region bit and spacing code.
// R8: Audio is muted during a seek regardless of mute-release and volume.
// R9: Region zero frequency is spacing times station index plus 87.5 MHz.
// R10: Tune request bit starts tune to the target station index.
// R11: Completion sets tune-complete flag and interrupt when enabled.
// R12: Status reports stereo indication and 8-bit signal strength.
// R13: Readback register reports current station index, 10 bits.
// R14: Tune request written low ends tune and clears tune-complete flag.
// R15: Host waits for tune-complete clear before a new request.
// R16: Scan request starts a seek; direction bit high means upward.
// R17: Seek covering band without strong enough channel sets scan-failed flag.
// R18: Scan request written low ends seek and clears tune-complete flag.
// R19: Data-ready bit set on new corrected group, only on capable variant.
// R20: 3-bit error count reports errors in four blocks; zero means none.
// R21: Four read-only registers hold the four 16-bit data blocks.
// R22: Identity registers hold part, maker, step, variant bit and microcode version.
// R23: Write burst starts at power configuration upper byte, increments, wraps.
// R24: Read burst starts at status upper byte, increments, wraps.
// R25: General pin returns high once causing conditions are cleared.
`include "tcs_regs_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module tcs_regs #(
  parameter [3:0] PART_CODE = 4'h3,
  // Arbitrary maker value.
  parameter [11:0] MAKER_CODE = 12'h5a5,
  parameter [5:0] SILICON_STEP = 6'h01,
  parameter VARIANT_BIT = 1'b1,
  parameter [8:0] MICROCODE_VERSION = 9'h001,
  parameter [15:0] TUNE_CYCLES = 16'h0010,
  parameter [15:0] POWERDOWN_CYCLES = 16'h0010,
  parameter [15:0] SEEK_STEP_CYCLES = 16'h0004
) (
  // Clock, reset, enable
  input wire mclk,
  input wire rst,
  input wire ce,
  // Byte port from the serial front end
  input wire burstStart,
  input wire burstRead,
  input wire wrByteValid,
  input wire [7:0] wrByte,
  input wire rdByteReq,
  output reg [7:0] rdByte,
  output reg rdByteValid,
  // Analog section status
  input wire [7:0] signalLevelIn,
  input wire stereoIn,
  input wire rdsGroupValid,
  input wire [15:0] rdsBlockAIn,
  input wire [15:0] rdsBlockBIn,
  input wire [15:0] rdsBlockCIn,
  input wire [15:0] rdsBlockDIn,
  input wire [2:0] rdsErrorIn,
  // Analog section control
  output reg [1:0] powerState,
  output reg [9:0] tunedStationIndex,
  output reg [17:0] tunedFreqKhz,
  output reg seekActive,
  output reg audioMute,
  output reg [3:0] volume,
  output reg emphasisSelect,
  // General pin two
  output reg generalPinTwoOut,
  output reg generalPinTwoOe
);
  localparam PS_DOWN = 2'h0;
  localparam PS_ON = 2'h1;
  localparam PS_SEQ = 2'h2;
  localparam PS_PARTIAL = 2'h3;
  localparam TS_IDLE = 2'h0;
  localparam TS_TUNE = 2'h1;
  localparam TS_SEEK = 2'h2;
  localparam TS_DONE = 2'h3;

  function [9:0] bandTop;
    input region;
    input [1:0] space;
    begin
      if (space == `TCS_SP_200)
        bandTop = region ? `TCS_TOP1_200 : `TCS_TOP0_200;
      else if (space == `TCS_SP_100)
        bandTop = region ? `TCS_TOP1_100 : `TCS_TOP0_100;
      else
        bandTop = region ? `TCS_TOP1_50 : `TCS_TOP0_50;
    end
  endfunction

  function [17:0] spacingKhz;
    input [1:0] space;
    begin
      if (space == `TCS_SP_200)
        spacingKhz = `TCS_KHZ_200;
      else if (space == `TCS_SP_100)
        spacingKhz = `TCS_KHZ_100;
      else
        spacingKhz = `TCS_KHZ_50;
    end
  endfunction

  reg [15:0] power_reg;
  reg [15:0] channel_reg;
  reg [15:0] cfg1_reg;
  reg [15:0] cfg2_reg;
  reg [1:0] pstate_reg;
  reg [15:0] pcount_reg;
  reg [1:0] tstate_reg;
  reg [15:0] tcount_reg;
  reg [9:0] station_reg;
  reg moved_reg;
  reg stc_reg;
  reg scanFail_reg;
  reg rdsReady_reg;
  reg [2:0] rdsErr_reg;
  reg [15:0] rds_block_a_reg;
  reg [15:0] rds_block_b_reg;
  reg [15:0] rds_block_c_reg;
  reg [15:0] rds_block_d_reg;
  reg [4:0] ptr_reg;
  reg [7:0] hold_reg;
  reg [15:0] readWord;

  wire [3:0] ptrIdx = ptr_reg[4:1];
  wire commit = ce && wrByteValid && ptr_reg[0];
  wire [15:0] wrWord = {hold_reg, wrByte};
  wire powered = (pstate_reg == PS_ON);
  wire [9:0] topIdx = bandTop(cfg2_reg[`TCS_C2_REGION], cfg2_reg[`TCS_C2_SP_HI:`TCS_C2_SP_LO]);
  wire [1:0] gpMode = cfg1_reg[`TCS_C1_GP2_HI:`TCS_C1_GP2_LO];
  wire [7:0] threshold = cfg2_reg[`TCS_C2_TH_HI:`TCS_C2_TH_LO];
  wire scanUp = power_reg[`TCS_PWR_SCAN_UP];
  wire atEdge = scanUp ? (station_reg >= topIdx) : (station_reg == 10'h000);
  // A burst opening in the same cycle wins over the read, so it must not clear the flag either.
  wire rdsDrained = ce && rdByteReq && !burstStart && !wrByteValid && (ptrIdx == `TCS_REG_RDS_D) && ptr_reg[0];
  wire rdsCapable = (VARIANT_BIT == 1'b1);
  wire irqActive = (stc_reg && cfg1_reg[`TCS_C1_TUNE_IEN]) ||
    (rdsReady_reg && cfg1_reg[`TCS_C1_RDS_IEN]);
  wire [17:0] baseKhz = cfg2_reg[`TCS_C2_REGION] ? `TCS_BASE1_KHZ : `TCS_BASE0_KHZ;
  wire [27:0] stepProduct = spacingKhz(cfg2_reg[`TCS_C2_SP_HI:`TCS_C2_SP_LO]) * station_reg;

  // Identity words: variant bit and microcode read zero whenever the receiver is not in operation.
  always @*
  begin
    case (ptrIdx)
      `TCS_REG_DEVICE_ID: readWord = {PART_CODE, MAKER_CODE}; // see R22
      `TCS_REG_CHIP_ID: readWord = powered ? {SILICON_STEP, VARIANT_BIT, MICROCODE_VERSION} :
        {SILICON_STEP, 10'h000}; // see R22
      `TCS_REG_POWER: readWord = power_reg;
      `TCS_REG_CHANNEL: readWord = channel_reg;
      `TCS_REG_SYSCFG1: readWord = cfg1_reg;
      `TCS_REG_SYSCFG2: readWord = cfg2_reg;
      `TCS_REG_STATUS: readWord = {rdsReady_reg, stc_reg, scanFail_reg, 1'b0, rdsErr_reg, stereoIn,
        signalLevelIn}; // see R12
      `TCS_REG_READBACK: readWord = {6'h00, station_reg}; // see R13
      `TCS_REG_RDS_A: readWord = rds_block_a_reg; // see R21
      `TCS_REG_RDS_B: readWord = rds_block_b_reg;
      `TCS_REG_RDS_C: readWord = rds_block_c_reg;
      `TCS_REG_RDS_D: readWord = rds_block_d_reg;
      default: readWord = 16'h0000;
    endcase
  end

  // Byte port: a word is committed when its lower byte arrives; read-only words ignore writes.
  always @(posedge mclk)
  begin
    if (rst)
    begin
      ptr_reg <= 5'h00;
      hold_reg <= 8'h00;
      rdByte <= 8'h00;
      rdByteValid <= 1'b0;
    end
    else if (ce)
    begin
      rdByteValid <= 1'b0;
      if (burstStart)
        ptr_reg <= burstRead ? {`TCS_RD_START, 1'b0} : {`TCS_WR_START, 1'b0}; // see R23 see R24
      else if (wrByteValid)
      begin
        if (!ptr_reg[0])
          hold_reg <= wrByte;
        ptr_reg <= ptr_reg + 5'h01; // see R23
      end
      else if (rdByteReq)
      begin
        rdByte <= ptr_reg[0] ? readWord[7:0] : readWord[15:8];
        rdByteValid <= 1'b1;
        ptr_reg <= ptr_reg + 5'h01; // see R24
      end
    end
  end

  // Configuration registers and the power sequence.
  always @(posedge mclk)
  begin
    if (rst)
    begin
      power_reg <= 16'h0000;
      channel_reg <= 16'h0000;
      cfg1_reg <= 16'h0000;
      cfg2_reg <= 16'h0000;
      pstate_reg <= PS_DOWN;
      pcount_reg <= 16'h0000;
    end
    else if (ce)
    begin
      if (commit && ptrIdx == `TCS_REG_CHANNEL)
        channel_reg <= wrWord & `TCS_CH_MASK; // see R10 see R14
      if (commit && ptrIdx == `TCS_REG_SYSCFG1)
        cfg1_reg <= wrWord & `TCS_C1_MASK;
      if (commit && ptrIdx == `TCS_REG_SYSCFG2)
        cfg2_reg <= wrWord & `TCS_C2_MASK; // see R7
      if (commit && ptrIdx == `TCS_REG_POWER)
      begin
        power_reg <= wrWord & `TCS_PWR_MASK;
        if (wrWord[`TCS_PWR_ON] && !wrWord[`TCS_PWR_OFF])
          pstate_reg <= PS_ON; // see R1
        else if (wrWord[`TCS_PWR_ON])
        begin
          pstate_reg <= PS_SEQ; // see R2
          pcount_reg <= 16'h0000;
        end
        else if (pstate_reg != PS_DOWN)
          pstate_reg <= PS_PARTIAL; // see R3
      end
      else if (pstate_reg == PS_SEQ)
      begin
        // A host write to the power register during the sequence takes priority over the automatic clear.
        if (pcount_reg == POWERDOWN_CYCLES - 16'h0001)
        begin
          power_reg[`TCS_PWR_ON] <= 1'b0; // see R2
          pstate_reg <= PS_DOWN;
        end
        else
          pcount_reg <= pcount_reg + 16'h0001;
      end
    end
  end

  // Tune and seek sequencing; the flag stays up until both request bits are low.
  always @(posedge mclk)
  begin
    if (rst)
    begin
      tstate_reg <= TS_IDLE;
      tcount_reg <= 16'h0000;
      station_reg <= 10'h000;
      moved_reg <= 1'b0;
      stc_reg <= 1'b0;
      scanFail_reg <= 1'b0;
    end
    else if (ce && powered)
    begin
      case (tstate_reg)
        TS_IDLE:
        begin
          tcount_reg <= 16'h0000;
          moved_reg <= 1'b0;
          if (channel_reg[`TCS_CH_TUNE])
          begin
            station_reg <= channel_reg[9:0]; // see R10
            tstate_reg <= TS_TUNE;
          end
          else if (power_reg[`TCS_PWR_SCAN])
          begin
            scanFail_reg <= 1'b0;
            tstate_reg <= TS_SEEK; // see R16
          end
        end
        TS_TUNE:
        begin
          if (!channel_reg[`TCS_CH_TUNE])
            tstate_reg <= TS_IDLE; // see R14
          else if (tcount_reg == TUNE_CYCLES - 16'h0001)
          begin
            stc_reg <= 1'b1; // see R11
            tstate_reg <= TS_DONE;
          end
          else
            tcount_reg <= tcount_reg + 16'h0001;
        end
        TS_SEEK:
        begin
          if (!power_reg[`TCS_PWR_SCAN])
            tstate_reg <= TS_IDLE; // see R18
          else if (tcount_reg != SEEK_STEP_CYCLES - 16'h0001)
            tcount_reg <= tcount_reg + 16'h0001;
          else
          begin
            tcount_reg <= 16'h0000;
            if (moved_reg && signalLevelIn >= threshold)
            begin
              stc_reg <= 1'b1; // see R11
              tstate_reg <= TS_DONE;
            end
            else if (atEdge)
            begin
              scanFail_reg <= 1'b1; // see R17
              stc_reg <= 1'b1;
              tstate_reg <= TS_DONE;
            end
            else
            begin
              station_reg <= scanUp ? station_reg + 10'h001 : station_reg - 10'h001; // see R16
              moved_reg <= 1'b1;
            end
          end
        end
        TS_DONE:
        begin
          // The host must not re-request until the flag drops, so a fresh request is not latched here.
          if (!channel_reg[`TCS_CH_TUNE] && !power_reg[`TCS_PWR_SCAN])
          begin
            stc_reg <= 1'b0; // see R14 see R18 see R15
            tstate_reg <= TS_IDLE;
          end
        end
        default: tstate_reg <= TS_IDLE;
      endcase
    end
  end

  // Data groups: a new group sets the ready flag, which wins over the clear by a final read.
  always @(posedge mclk)
  begin
    if (rst)
    begin
      rdsReady_reg <= 1'b0;
      rdsErr_reg <= 3'h0;
      rds_block_a_reg <= 16'h0000;
      rds_block_b_reg <= 16'h0000;
      rds_block_c_reg <= 16'h0000;
      rds_block_d_reg <= 16'h0000;
    end
    else if (ce)
    begin
      if (rdsGroupValid && rdsCapable && powered && cfg1_reg[`TCS_C1_RDS_EN])
      begin
        rdsReady_reg <= 1'b1; // see R19
        rdsErr_reg <= rdsErrorIn; // see R20
        rds_block_a_reg <= rdsBlockAIn; // see R21
        rds_block_b_reg <= rdsBlockBIn;
        rds_block_c_reg <= rdsBlockCIn;
        rds_block_d_reg <= rdsBlockDIn;
      end
      else if (rdsDrained)
        rdsReady_reg <= 1'b0;
    end
  end

  // Registered outputs towards the analog section and the general pin.
  always @(posedge mclk)
  begin
    if (rst)
    begin
      powerState <= PS_DOWN;
      tunedStationIndex <= 10'h000;
      tunedFreqKhz <= 18'h00000;
      seekActive <= 1'b0;
      audioMute <= 1'b1;
      volume <= 4'h0;
      emphasisSelect <= 1'b0;
      generalPinTwoOut <= 1'b1;
      generalPinTwoOe <= 1'b0;
    end
    else if (ce)
    begin
      powerState <= pstate_reg;
      tunedStationIndex <= station_reg;
      tunedFreqKhz <= baseKhz + stepProduct[17:0]; // see R9
      seekActive <= (tstate_reg == TS_SEEK);
      audioMute <= !powered || !power_reg[`TCS_PWR_MUTE_REL] || (tstate_reg == TS_SEEK); // see R1 see R8
      volume <= (tstate_reg == TS_SEEK) ? 4'h0 : cfg2_reg[`TCS_C2_VOL_HI:0]; // see R8
      emphasisSelect <= cfg1_reg[`TCS_C1_EMPH]; // see R6
      generalPinTwoOe <= (gpMode != `TCS_GP_HIZ);
      if (gpMode == `TCS_GP_IRQ)
        generalPinTwoOut <= !irqActive; // see R4 see R5 see R25
      else
        generalPinTwoOut <= (gpMode != `TCS_GP_LOW);
    end
  end
endmodule // tcs_regs
`default_nettype wire

/* File: tb/tcs_host.sv */
// Host model of the byte port: opens bursts and moves whole 16-bit words, upper byte first.
// Assumes the bank takes requests on rising mclk and answers each read request one cycle later.
`timescale 1ns/1ps
`default_nettype none
module tcs_host (
  // Clock
  input wire logic mclk,
  // Byte port
  output logic burstStart,
  output logic burstRead,
  output logic wrByteValid,
  output logic [7:0] wrByte,
  output logic rdByteReq,
  input wire logic [7:0] rdByte
);
  initial
  begin
    burstStart = 1'b0;
    burstRead = 1'b0;
    wrByteValid = 1'b0;
    wrByte = 8'h00;
    rdByteReq = 1'b0;
  end
  task automatic step();
    @(posedge mclk);
    #1;
  endtask
  // Released qualifiers show the inverse so a stale value is never mistaken for a held one.
  task automatic open_burst(input logic rd);
    burstStart = 1'b1;
    burstRead = rd;
    step();
    burstStart = 1'b0;
    burstRead = ~rd;
  endtask
  task automatic wr_word(input logic [15:0] w);
    wrByteValid = 1'b1;
    wrByte = w[15:8];
    step();
    wrByte = w[7:0];
    step();
    wrByteValid = 1'b0;
    wrByte = ~w[7:0];
    step();
  endtask
  task automatic rd_word(output logic [15:0] w);
    rdByteReq = 1'b1;
    step();
    w[15:8] = rdByte;
    step();
    rdByteReq = 1'b0;
    w[7:0] = rdByte;
    step();
  endtask
endmodule // tcs_host
`default_nettype wire

/* File: tb/tcs_regs_monitor.sv */
// Checker of the register bank ports: read answers, muting, pin drive and sequence bounds.
// Assumes one clock mclk with synchronous active-high rst; bound to every bank instance.
`timescale 1ns/1ps
`default_nettype none
module tcs_regs_mon #(
  parameter [15:0] POWERDOWN_CYCLES = 16'h0010,
  parameter [15:0] SEEK_STEP_CYCLES = 16'h0004
) (
  // Clock, reset and enable
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  // Byte port
  input wire logic burstStart,
  input wire logic wrByteValid,
  input wire logic rdByteReq,
  input wire logic [7:0] rdByte,
  input wire logic rdByteValid,
  // Control outputs
  input wire logic [1:0] powerState,
  input wire logic seekActive,
  input wire logic audioMute,
  input wire logic [3:0] volume,
  input wire logic generalPinTwoOut,
  input wire logic generalPinTwoOe
);
  // A seek crosses at most 410 stations; the slack covers the compare and the flag update.
  localparam int PD_BOUND = POWERDOWN_CYCLES + 8;
  localparam int SK_BOUND = 420 * SEEK_STEP_CYCLES + 16;
  // A seek can outlast any delay range, so its length is counted here instead.
  int seekLen;
  always @(posedge mclk)
  begin
    if (rst || !seekActive)
      seekLen <= 0;
    else if (ce && seekLen <= SK_BOUND)
      seekLen <= seekLen + 1;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  sequence readTaken;
    ce && rdByteReq && !burstStart && !wrByteValid;
  endsequence
  sequence pdStart;
    $rose(powerState == 2'h2);
  endsequence
  rd_answer_a: assert property (readTaken |=> rdByteValid)
    else $error("read byte not answered");
  rd_cause_a: assert property (rdByteValid |-> $past(rdByteReq))
    else $error("read byte without request");
  rd_hold_a: assert property (!rdByteValid |-> $stable(rdByte))
    else $error("read byte changed without answer");
  seek_mute_a: assert property (seekActive [*2] |-> audioMute && volume == 4'h0)
    else $error("audio live during seek");
  off_mute_a: assert property (powerState != 2'h1 |-> audioMute)
    else $error("audio live while not operating");
  pin_drive_a: assert property (!generalPinTwoOut |-> generalPinTwoOe)
    else $error("pin low but not driven");
  pd_finish_a: assert property (pdStart |-> ##[1:PD_BOUND] powerState == 2'h0)
    else $error("power-down sequence did not finish");
  seek_end_a: assert property (seekLen <= SK_BOUND)
    else $error("seek did not end");
endmodule // tcs_regs_mon
bind tcs_regs tcs_regs_mon #(
  .POWERDOWN_CYCLES(POWERDOWN_CYCLES),
  .SEEK_STEP_CYCLES(SEEK_STEP_CYCLES)
) mon (.mclk, .rst, .ce, .burstStart, .wrByteValid, .rdByteReq, .rdByte, .rdByteValid, .powerState,
  .seekActive, .audioMute, .volume, .generalPinTwoOut, .generalPinTwoOe);
`default_nettype wire

/* File: tb/tb.sv */
// Self-checking bench of the register bank: bursts, tune, seek, data groups and power control.
// Assumes the host model drives the byte port while the bench plays the analog section.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin miscompares++; $display("BAD t=%0t %h %h", $time, a, e); end end
module tb;
  // Identity values are arbitrary.
  localparam logic [3:0] PART = 4'h9;
  localparam logic [11:0] MAKER = 12'h6c3;
  localparam logic [5:0] STEP = 6'h05;
  localparam logic [8:0] UCODE = 9'h0a7;
  logic mclk, rst, ce, burstStart, burstRead, wrByteValid, rdByteReq, rdByteValid, stereoIn, rdsGroupValid;
  logic seekActive, audioMute, emphasisSelect, generalPinTwoOut, generalPinTwoOe;
  logic [7:0] wrByte, rdByte, signalLevelIn, lvl;
  logic [15:0] blkIn [4];
  logic [15:0] rdw [16];
  logic [15:0] lfsr_reg;
  logic [2:0] rdsErrorIn;
  logic [1:0] powerState;
  logic [9:0] tunedStationIndex;
  logic [17:0] tunedFreqKhz;
  logic [3:0] volume, vol;
  int miscompares, checks;
  tcs_regs #(.PART_CODE(PART), .MAKER_CODE(MAKER), .SILICON_STEP(STEP), .VARIANT_BIT(1'b1),
    .MICROCODE_VERSION(UCODE), .TUNE_CYCLES(16'h0004), .POWERDOWN_CYCLES(16'h0004),
    .SEEK_STEP_CYCLES(16'h0002)) uut (.mclk, .rst, .ce, .burstStart, .burstRead, .wrByteValid, .wrByte,
    .rdByteReq, .rdByte, .rdByteValid, .signalLevelIn, .stereoIn, .rdsGroupValid, .rdsBlockAIn(blkIn[0]),
    .rdsBlockBIn(blkIn[1]), .rdsBlockCIn(blkIn[2]), .rdsBlockDIn(blkIn[3]), .rdsErrorIn, .powerState,
    .tunedStationIndex, .tunedFreqKhz, .seekActive, .audioMute, .volume, .emphasisSelect,
    .generalPinTwoOut, .generalPinTwoOe);
  tcs_host host (.mclk, .burstStart, .burstRead, .wrByteValid, .wrByte, .rdByteReq, .rdByte);
  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic final_report();
    $display("Counts: checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
    begin
      $display("All checks passed");
    end
    else
    begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic wr_words(input logic [15:0] w [$]);
    host.open_burst(1'b0);
    foreach (w[i])
    begin
      host.wr_word(w[i]);
    end
  endtask
  // The read burst starts at the status word, so entry 16 lands back on index 0Ah - 1.
  task automatic read_all();
    host.open_burst(1'b1);
    for (int i = 0; i < 16; i++)
    begin
      host.rd_word(rdw[(10 + i) % 16]);
    end
  endtask
  task automatic wait_pin(input logic lvlWant);
    int n;
    n = 0;
    while (generalPinTwoOut !== lvlWant && n < 3000)
    begin
      host.step();
      n++;
    end
    `CHK(generalPinTwoOut, lvlWant)
    if (n == 3000)
    begin
      final_report();
    end
  endtask
  initial
  begin
    {ce, rst, stereoIn, rdsGroupValid, rdsErrorIn} = 7'h61;
    blkIn = '{default: 16'h0};
    miscompares = 0;
    checks = 0;
    lfsr_reg = lfsr_next(16'hbaab);
    lvl = lfsr_reg[15:8];
    vol = lfsr_reg[3:0];
    signalLevelIn = lvl;
    stereoIn = lfsr_reg[4];
    repeat (6) host.step();
    rst = 1'b0;
    `CHK({powerState, audioMute, generalPinTwoOut, generalPinTwoOe, rdByteValid}, 6'h0c);
    read_all();
    `CHK(rdw[0], {PART, MAKER});
    `CHK(rdw[1], {STEP, 10'h000});
    `CHK(rdw[10], {7'h00, stereoIn, lvl});
    `CHK(rdw[12], 16'h0000);
    wr_words('{16'h4001, 16'h0000, 16'hc004, {8'h3f, 4'h0, vol}, 16'hffff});
    host.step();
    `CHK({powerState, audioMute, volume, emphasisSelect}, {2'h1, 1'b0, vol, 1'b0});
    read_all();
    `CHK(rdw[1], {STEP, 1'b1, UCODE});
    `CHK(rdw[5], {8'h3f, 4'h0, vol});
    `CHK(rdw[6], 16'h0000);
    wr_words('{16'h4001, 16'h8050});
    wait_pin(1'b0);
    read_all();
    `CHK(rdw[10][14], 1'b1);
    `CHK(rdw[11][9:0], 10'h050);
    `CHK(tunedFreqKhz, 18'(87500 + 200 * 80));
    wr_words('{16'h4001, 16'h0050});
    wait_pin(1'b1);
    read_all();
    `CHK(rdw[10][14], 1'b0);
    signalLevelIn = 8'h10;
    wr_words('{16'h4301});
    host.step();
    `CHK({seekActive, audioMute, volume}, 6'h30);
    wait_pin(1'b0);
    read_all();
    `CHK(rdw[10][14:13], 2'h3);
    `CHK(tunedStationIndex, 10'h066);
    wr_words('{16'h4001});
    wait_pin(1'b1);
    read_all();
    `CHK(rdw[10][14], 1'b0);
    signalLevelIn = 8'h40;
    wr_words('{16'h4101});
    wait_pin(1'b0);
    `CHK(tunedStationIndex, 10'h065);
    wr_words('{16'h4001, 16'h0050, 16'hd004});
    wait_pin(1'b1);
    for (int i = 0; i < 4; i++)
    begin
      lfsr_reg = lfsr_next(lfsr_reg);
      blkIn[i] = lfsr_reg;
    end
    rdsErrorIn = lfsr_reg[2:0];
    rdsGroupValid = 1'b1;
    host.step();
    rdsGroupValid = 1'b0;
    wait_pin(1'b0);
    read_all();
    `CHK({rdw[10][15], rdw[10][11:9]}, {1'b1, blkIn[3][2:0]});
    for (int i = 0; i < 4; i++)
    begin
      `CHK(rdw[12 + i], blkIn[i]);
    end
    wait_pin(1'b1);
    wr_words('{16'h0041});
    repeat (12) host.step();
    `CHK(powerState, 2'h0);
    read_all();
    `CHK(rdw[2][0], 1'b0);
    wr_words('{16'h4001});
    wr_words('{16'h4000});
    host.step();
    `CHK(powerState, 2'h3);
    // With the clock enable low the bank must ignore a whole configuration burst.
    ce = 1'b0;
    wr_words('{16'h0000, 16'h0000, 16'h0808, {8'h00, 4'h5, vol}});
    `CHK({generalPinTwoOut, generalPinTwoOe, emphasisSelect, powerState}, 5'h1b);
    ce = 1'b1;
    wr_words('{16'h0000, 16'h0000, 16'h0808, {8'h00, 4'h5, vol}});
    host.step();
    `CHK({generalPinTwoOut, generalPinTwoOe, emphasisSelect, audioMute}, 4'h7);
    `CHK(tunedFreqKhz, 18'(76000 + 100 * 101));
    final_report();
  end
endmodule // tb
`default_nettype wire
